// ### hw/miwc_pkg.sv
// shared constants and types for the interrupt and wakeup controller
package miwc_pkg;
  // register addresses
  localparam logic [7:0] ADDR_POWER     = 8'h87;
  localparam logic [7:0] ADDR_STBY      = 8'ha4;
  localparam logic [7:0] ADDR_WAKE      = 8'ha5;
  localparam logic [7:0] ADDR_EN_FIRST  = 8'ha8;
  localparam logic [7:0] ADDR_EN_SECOND = 8'hb8;
  // reset values and write masks
  localparam logic [7:0] RST_REG    = 8'h00;
  localparam logic [7:0] IEN_WMASK  = 8'hbf;
  localparam logic [7:0] POWER_WMASK = 8'hfc;
  localparam logic [7:0] STBY_CMD   = 8'h07;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;
  // field positions
  localparam int POWER_BAUD  = 7;
  localparam int POWER_PMW   = 4;
  localparam int POWER_STOP  = 1;
  localparam int POWER_IDLE  = 0;
  localparam int STBY_LF     = 3;
  localparam int EN_GLOBAL   = 7;
  // wake field encodings
  localparam logic [1:0] WAKE_IF_EN  = 2'h0;
  localparam logic [1:0] WAKE_ALWAYS = 2'h2;
  localparam logic [1:0] WAKE_IGNORE = 2'h3;
  // sources and vector slots
  localparam int NUM_SRC  = 15;
  localparam int NUM_SLOT = 14;
  localparam int NUM_WAKE = 4;
  localparam int SLOT_W   = 4;
  localparam int VEC_W    = 16;
  localparam logic [2:0] VEC_LOW  = 3'h3;
  localparam logic [7:0] VEC_HIGH = 8'h00;
  localparam int SRC_PIN3 = 0, SRC_TMR0 = 1, SRC_CIPHER = 2, SRC_TMR1 = 3, SRC_SER_RX = 4;
  localparam int SRC_SER_TX = 5, SRC_TMR2 = 6, SRC_TMR2_EXT = 7, SRC_RADIO_SPI = 8;
  localparam int SRC_RADIO = 9, SRC_SPI_MST = 10, SRC_SPI_SLV = 11, SRC_USB_WAKE = 12;
  localparam int SRC_USB = 13, SRC_INT_WAKE = 14;
  typedef enum logic [1:0] {MIWC_LEVEL_HI, MIWC_EDGE_FALL, MIWC_EDGE_RISE, MIWC_EDGE_BOTH}
    miwc_sense_t;
  localparam miwc_sense_t SRC_SENSE [NUM_SRC] = '{
    MIWC_EDGE_FALL, MIWC_LEVEL_HI, MIWC_EDGE_FALL, MIWC_LEVEL_HI, MIWC_LEVEL_HI,
    MIWC_LEVEL_HI, MIWC_LEVEL_HI, MIWC_LEVEL_HI, MIWC_LEVEL_HI, MIWC_EDGE_BOTH,
    MIWC_EDGE_BOTH, MIWC_EDGE_BOTH, MIWC_EDGE_RISE, MIWC_EDGE_RISE, MIWC_EDGE_RISE};
  // slot n sits at vector address 8*n+3
  localparam logic [SLOT_W-1:0] SRC_SLOT [NUM_SRC] = '{
    4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h4, 4'h5, 4'h5, 4'h8, 4'h9, 4'ha, 4'ha, 4'hb, 4'hc, 4'hd};
  // enable bit index into {second, first} enable registers
  localparam logic [3:0] SRC_EN [NUM_SRC] = '{
    4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h4, 4'h5, 4'h5, 4'h8, 4'h9, 4'ha, 4'ha, 4'hb, 4'hc, 4'hd};
  // wake sources: radio, internal, usb irq, usb wake
  localparam int WAKE_SRC [NUM_WAKE] = '{SRC_RADIO, SRC_INT_WAKE, SRC_USB, SRC_USB_WAKE};
  localparam int WAKE_LO  [NUM_WAKE] = '{6, 4, 2, 0};
  localparam int WAKE_EN  [NUM_WAKE] = '{1, 5, 4, 3};
  typedef enum logic [1:0] {MIWC_RUN, MIWC_IDLE, MIWC_STOP, MIWC_STANDBY} miwc_power_t;
endpackage

// ### hw/miwc_src_if.sv
// source requests between the edge detector and the controller
`timescale 1ns/100ps
interface miwc_src_if;
  import miwc_pkg::*;
  logic [NUM_SRC-1:0] raw;
  logic [NUM_SRC-1:0] pending;
  logic [NUM_SRC-1:0] clr;
  modport det (input raw, input clr, output pending);
  modport ctl (output raw, output clr, input pending);
endinterface

// ### hw/miwc_src_det.sv
// per-source level pass or edge latch
`timescale 1ns/100ps
module miwc_src_det
  import miwc_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // sources
  miwc_src_if.det   src
);
  genvar i;
  generate
    for (i = 0; i < NUM_SRC; i++) begin : g_src
      if (SRC_SENSE[i] == MIWC_LEVEL_HI) begin : g_lvl
        assign src.pending[i] = src.raw[i];
      end else begin : g_edge
        logic prev_q;
        logic latch_q;
        wire  edge_hit;
        if (SRC_SENSE[i] == MIWC_EDGE_FALL) begin : g_fall
          assign edge_hit = prev_q & ~src.raw[i];
        end else if (SRC_SENSE[i] == MIWC_EDGE_RISE) begin : g_rise
          assign edge_hit = ~prev_q & src.raw[i];
        end else begin : g_both
          assign edge_hit = prev_q ^ src.raw[i];
        end
        // low-active sources idle high; a new edge wins over a clear in the same cycle
        always_ff @(posedge clk or negedge rst_b) begin
          if (!rst_b) begin
            prev_q  <= (SRC_SENSE[i] == MIWC_EDGE_FALL);
            latch_q <= 1'b0;
          end else begin
            prev_q  <= src.raw[i];
            latch_q <= edge_hit | (latch_q & ~src.clr[i]);
          end
        end
        assign src.pending[i] = latch_q;
      end
    end
  endgenerate
endmodule

// ### hw/miwc_top.sv
// interrupt controller, wake configuration and power mode control
`timescale 1ns/100ps
// Overview of operation
// - radio wake field selects radio line wake
// - internal wake field selects internal event wake
// - usb irq field selects usb irq wake
// - usb wake field selects usb wake line
// - power bit 7 doubles serial baud
// - bits 6,5,3,2 are plain flags
// - bit 4 sets program memory write mode
// - writing bit 1 enters stop, reads zero
// - writing bit 0 enters idle, reads zero
// - fifteen sources combined into core requests
// - pin, timer 0, cipher vectors fixed
// - radio, usb wake, usb irq vectors fixed
// - higher priority request preempts running routine
// - serial receive and transmit share vector
// - timer 2 overflow and event share vector
// - spi master and slave share vector
// - global enable bit gates all requests
// - first enable bits 0..2 per source
// - first enable bits 3..5, bit 6 unused
// - second enable bits gate radio, usb, wake
// - standby command with any of bits 2..0 set enters standby
module miwc_top
  import miwc_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // special function register port
  input  wire logic [7:0]        sfr_addr,
  input  wire logic [7:0]        sfr_wdata,
  input  wire logic              sfr_wr,
  input  wire logic              sfr_rd,
  output logic      [7:0]        sfr_rdata,
  // interrupt sources
  input  wire logic [NUM_SRC-1:0] src_raw,
  input  wire logic              lf_clk_level,
  // core handshake
  output logic                   irq_req,
  output logic      [VEC_W-1:0]  irq_vector,
  input  wire logic              irq_ack,
  input  wire logic              irq_reti,
  // mode outputs
  output logic                   baud_double,
  output logic                   prog_write_mode,
  output logic                   idle_mode,
  output logic                   stop_mode,
  output logic                   standby_mode
);
  miwc_src_if src ();
  miwc_src_det u_det (
    .clk   (clk),
    .rst_b (rst_b),
    .src   (src.det)
  );

  logic [7:0]           power_mode_control;
  logic [7:0]           wake_source_config;
  logic [7:0]           irq_enable_first;
  logic [7:0]           irq_enable_second;
  logic [NUM_SLOT-1:0]  in_service;
  logic [SLOT_W-1:0]    req_slot;
  miwc_power_t          power_state;
  miwc_power_t          next_power_state;

  // lowest set slot wins
  function automatic logic [SLOT_W:0] first_set(input logic [NUM_SLOT-1:0] v);
    logic [SLOT_W:0] r;
    r = '0;
    for (int k = NUM_SLOT - 1; k >= 0; k--) begin
      if (v[k]) begin
        r = {1'b1, SLOT_W'(k)};
      end
    end
    return r;
  endfunction

  // register decode
  wire wr_power     = sfr_wr && (sfr_addr == ADDR_POWER);
  wire wr_stby      = sfr_wr && (sfr_addr == ADDR_STBY);
  wire wr_wake      = sfr_wr && (sfr_addr == ADDR_WAKE);
  wire wr_en_first  = sfr_wr && (sfr_addr == ADDR_EN_FIRST);
  wire wr_en_second = sfr_wr && (sfr_addr == ADDR_EN_SECOND);

  wire [7:0] next_rdata =
    (sfr_addr == ADDR_POWER) ? power_mode_control :
    (sfr_addr == ADDR_STBY) ? (ZERO_BYTE | (8'h01 << STBY_LF) & {8{lf_clk_level}}) :
    (sfr_addr == ADDR_WAKE) ? wake_source_config :
    (sfr_addr == ADDR_EN_FIRST) ? irq_enable_first :
    (sfr_addr == ADDR_EN_SECOND) ? irq_enable_second : ZERO_BYTE;

  wire enter_stop    = wr_power && sfr_wdata[POWER_STOP];
  wire enter_idle    = wr_power && sfr_wdata[POWER_IDLE];
  wire enter_standby = wr_stby && ((sfr_wdata & STBY_CMD) != ZERO_BYTE);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      power_mode_control <= RST_REG;
      wake_source_config <= RST_REG;
      irq_enable_first   <= RST_REG;
      irq_enable_second  <= RST_REG;
      sfr_rdata          <= RST_REG;
    end else begin
      // stop and idle bits never hold a value
      if (wr_power)     power_mode_control <= sfr_wdata & POWER_WMASK;
      if (wr_wake)      wake_source_config <= sfr_wdata;
      if (wr_en_first)  irq_enable_first   <= sfr_wdata & IEN_WMASK;
      if (wr_en_second) irq_enable_second  <= sfr_wdata & IEN_WMASK;
      if (sfr_rd)  sfr_rdata          <= next_rdata;
    end
  end

  // request combining
  wire [15:0] en_bits = {irq_enable_second, irq_enable_first};
  wire        global_en = irq_enable_first[EN_GLOBAL];
  logic [NUM_SLOT-1:0] slot_req;
  logic [NUM_SRC-1:0]  src_clr;

  always_comb begin
    slot_req = '0;
    src_clr  = '0;
    for (int s = 0; s < NUM_SRC; s++) begin
      // shared vectors simply OR their sources
      if (src.pending[s] && en_bits[SRC_EN[s]] && global_en) begin
        slot_req[SRC_SLOT[s]] = 1'b1;
      end
      if (irq_ack && (SRC_SLOT[s] == req_slot)) begin
        src_clr[s] = 1'b1;
      end
    end
  end

  assign src.raw = src_raw;
  assign src.clr = src_clr;

  wire [SLOT_W:0] cand = first_set(slot_req);
  wire [SLOT_W:0] busy = first_set(in_service);
  // a request issues only above every routine in service
  wire take = cand[SLOT_W] && (!busy[SLOT_W] || (cand[SLOT_W-1:0] < busy[SLOT_W-1:0]));
  wire [VEC_W-1:0] next_vector = {VEC_HIGH, 1'b0, cand[SLOT_W-1:0], VEC_LOW};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_req    <= 1'b0;
      irq_vector <= '0;
      req_slot   <= '0;
      in_service <= '0;
    end else begin
      irq_req <= take && !irq_ack;
      if (take && !irq_ack) begin
        irq_vector <= next_vector;
        req_slot   <= cand[SLOT_W-1:0];
      end
      for (int n = 0; n < NUM_SLOT; n++) begin
        if (irq_ack && (req_slot == SLOT_W'(n))) begin
          in_service[n] <= 1'b1;
        end else if (irq_reti && busy[SLOT_W] && (busy[SLOT_W-1:0] == SLOT_W'(n))) begin
          in_service[n] <= 1'b0;
        end
      end
    end
  end

  // wake permission per source
  logic [NUM_WAKE-1:0] wake_hit;
  genvar w;
  generate
    for (w = 0; w < NUM_WAKE; w++) begin : g_wake
      wire [1:0] fld = wake_source_config[WAKE_LO[w] +: 2];
      wire allowed = ((fld == WAKE_IF_EN) && irq_enable_second[WAKE_EN[w]]) ||
                     (fld == WAKE_ALWAYS);
      assign wake_hit[w] = allowed && src.pending[WAKE_SRC[w]];
    end
  endgenerate
  wire wake_any = |wake_hit;

  always_comb begin
    next_power_state = power_state;
    unique case (power_state)
      MIWC_RUN: begin
        if (enter_standby)   next_power_state = MIWC_STANDBY;
        else if (enter_stop) next_power_state = MIWC_STOP;
        else if (enter_idle) next_power_state = MIWC_IDLE;
      end
      MIWC_IDLE, MIWC_STOP, MIWC_STANDBY: begin
        if (wake_any) next_power_state = MIWC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      power_state     <= MIWC_RUN;
      idle_mode       <= 1'b0;
      stop_mode       <= 1'b0;
      standby_mode    <= 1'b0;
      baud_double     <= 1'b0;
      prog_write_mode <= 1'b0;
    end else begin
      power_state     <= next_power_state;
      idle_mode       <= (next_power_state == MIWC_IDLE);
      stop_mode       <= (next_power_state == MIWC_STOP);
      standby_mode    <= (next_power_state == MIWC_STANDBY);
      baud_double     <= wr_power ? sfr_wdata[POWER_BAUD] : power_mode_control[POWER_BAUD];
      prog_write_mode <= wr_power ? sfr_wdata[POWER_PMW] : power_mode_control[POWER_PMW];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_stop_write;
    wr_power && sfr_wdata[POWER_STOP] && power_state == MIWC_RUN && !enter_standby;
  endsequence
  sequence s_asleep;
    stop_mode ##1 stop_mode;
  endsequence

  a_global_gate: assert property (!global_en |=> !irq_req)
    else $error("request issued with global enable off");
  a_stop_enter: assert property (s_stop_write |=> stop_mode)
    else $error("stop write did not enter stop");
  a_stop_readzero: assert property (1'b1 |-> !power_mode_control[POWER_STOP] &&
                                    !power_mode_control[POWER_IDLE])
    else $error("stop or idle bit held a value");
  a_idle_enter: assert property (power_state == MIWC_RUN && enter_idle && !enter_stop &&
                                 !enter_standby |=> idle_mode)
    else $error("idle write did not enter idle");
  a_standby_enter: assert property (power_state == MIWC_RUN && enter_standby
                                    |=> standby_mode)
    else $error("standby command ignored");
  a_wake_exit: assert property ((idle_mode || stop_mode || standby_mode) && wake_any
                                |=> !idle_mode && !stop_mode && !standby_mode)
    else $error("permitted wake did not leave low power");
  // usb irq field at ignore, no other wake permitted: stop must hold
  a_ignore_wake: assert property (s_asleep ##0
                                  (wake_source_config[WAKE_LO[2] +: 2] == WAKE_IGNORE) &&
                                  !wake_hit[0] && !wake_hit[1] && !wake_hit[3] |=> stop_mode)
    else $error("ignored wake source woke the core");
  a_vector_addr: assert property ($rose(irq_req) |-> irq_vector[2:0] == VEC_LOW &&
                                  irq_vector[VEC_W-1:7] == '0 &&
                                  irq_vector[6:3] == $past(cand[SLOT_W-1:0]))
    else $error("vector address malformed");
  a_no_preempt_low: assert property (busy[SLOT_W] && cand[SLOT_W] &&
                                     cand[SLOT_W-1:0] >= busy[SLOT_W-1:0] |=> !irq_req)
    else $error("equal or lower request preempted");
  a_baud_follow: assert property (wr_power |=> baud_double == $past(sfr_wdata[POWER_BAUD]))
    else $error("baud doubler not following write");
endmodule

// ### verif/miwc_core_model.sv
// behavioural core that accepts requests, runs a short handler and returns
`timescale 1ns/100ps
module miwc_core_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // request side of the controller
  input  wire logic        irq_req,
  input  wire logic [15:0] irq_vector,
  input  wire logic        slow,
  output logic             irq_ack,
  output logic             irq_reti,
  // observation
  output logic             busy,
  output logic [15:0]      last_vec,
  output logic [7:0]       served
);
  logic [3:0] wait_cnt;
  logic [2:0] run_cnt;

  // one handler at a time; a slow core lets the request stand for five cycles
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_ack  <= 1'b0;
      irq_reti <= 1'b0;
      busy     <= 1'b0;
      last_vec <= 16'h0000;
      served   <= 8'h00;
      wait_cnt <= 4'h0;
      run_cnt  <= 3'h0;
    end else begin
      irq_ack  <= 1'b0;
      irq_reti <= 1'b0;
      if (busy) begin
        run_cnt <= run_cnt + 3'h1;
        if (run_cnt == 3'h4) begin
          irq_reti <= 1'b1;
          busy     <= 1'b0;
          served   <= served + 8'h01;
        end
      end else if (irq_req && !irq_ack) begin
        if (wait_cnt >= (slow ? 4'h5 : 4'h0)) begin
          irq_ack  <= 1'b1;
          last_vec <= irq_vector;
          busy     <= 1'b1;
          run_cnt  <= 3'h0;
          wait_cnt <= 4'h0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
endmodule

// ### verif/tb_top.sv
// self-checking bench for the interrupt and wakeup controller
`timescale 1ns/100ps
module tb_top;
  import miwc_pkg::*;
  logic               clk, rst_b, sfr_wr, sfr_rd, lf_clk_level, slow, busy;
  logic               irq_req, irq_ack, irq_reti;
  logic               baud_double, prog_write_mode, idle_mode, stop_mode, standby_mode;
  logic [7:0]         sfr_addr, sfr_wdata, sfr_rdata, served;
  logic [NUM_SRC-1:0] src_raw;
  logic [VEC_W-1:0]   irq_vector, last_vec;
  logic [15:0]        vec_tab [15] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023,
    16'h0023, 16'h002b, 16'h002b, 16'h0043, 16'h004b, 16'h0053, 16'h0053, 16'h005b,
    16'h0063, 16'h006b};
  int                 errors = 0;
  int                 total_checks = 0;

  miwc_top uut (.clk, .rst_b, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .src_raw,
    .lf_clk_level, .irq_req, .irq_vector, .irq_ack, .irq_reti, .baud_double,
    .prog_write_mode, .idle_mode, .stop_mode, .standby_mode);
  miwc_core_model core (.clk, .rst_b, .irq_req, .irq_vector, .slow, .irq_ack, .irq_reti,
    .busy, .last_vec, .served);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic close_out;
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic sig(int w);
    case (w)
      0: return irq_req;
      1: return busy;
      2: return stop_mode;
      3: return idle_mode;
      default: return standby_mode;
    endcase
  endfunction

  task automatic wait_for(int w, logic v);
    for (int i = 0; i < 30; i++) begin
      if (sig(w) === v) return;
      @(negedge clk);
    end
    chk("wait_for", 16'(sig(w)), 16'(v));
    close_out;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge clk);
    sfr_wr    = 1'b0;
  endtask

  task automatic rd_chk(string nm, logic [7:0] a, logic [7:0] exp);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge clk);
    sfr_rd   = 1'b0;
    @(negedge clk);
    chk(nm, {8'h00, sfr_rdata}, {8'h00, exp});
  endtask

  // one event of the source's own sense: fall, rise or either edge
  task automatic kick(int s);
    @(negedge clk);
    if (s == 0 || s == 2) begin
      src_raw[s] = 1'b1;
      @(negedge clk);
      src_raw[s] = 1'b0;
    end else if (s >= 12) begin
      src_raw[s] = 1'b0;
      @(negedge clk);
      src_raw[s] = 1'b1;
    end else begin
      src_raw[s] = ~src_raw[s];
    end
  endtask

  task automatic t_regs;
    rd_chk("power_reset", ADDR_POWER, 8'h00);
    rd_chk("enable_reset", ADDR_EN_FIRST, 8'h00);
    wr(ADDR_POWER, 8'hfc);
    rd_chk("power_flags", ADDR_POWER, 8'hfc);
    chk("baud_double", 16'(baud_double), 16'h0001);
    chk("prog_write_on", 16'(prog_write_mode), 16'h0001);
    wr(ADDR_POWER, 8'h00);
    rd_chk("power_clear", ADDR_POWER, 8'h00);
    chk("prog_write_off", 16'(prog_write_mode), 16'h0000);
    chk("baud_off", 16'(baud_double), 16'h0000);
    wr(ADDR_EN_FIRST, 8'hff);
    rd_chk("enable_unused_bit", ADDR_EN_FIRST, 8'hbf);
    wr(ADDR_EN_SECOND, 8'hff);
    rd_chk("enable_second", ADDR_EN_SECOND, 8'hbf);
    wr(ADDR_WAKE, 8'ha3);
    rd_chk("wake_fields", ADDR_WAKE, 8'ha3);
    lf_clk_level = 1'b1;
    rd_chk("standby_read", ADDR_STBY, 8'h08);
    rd_chk("unmapped_read", 8'h90, 8'h00);
  endtask

  task automatic serve_src(int s);
    logic       lvl;
    logic [7:0] s0;
    lvl  = (s == 1) || (s >= 3 && s <= 8);
    slow = s[0];
    if (lvl) begin
      @(negedge clk);
      src_raw[s] = 1'b1;
    end else begin
      kick(s);
    end
    wait_for(0, 1'b1);
    chk("vector", irq_vector, vec_tab[s]);
    s0 = served;
    wait_for(1, 1'b1);
    // an edge source stays put: restoring a both-edge source would raise a second request
    if (lvl) src_raw[s] = 1'b0;
    wait_for(1, 1'b0);
    chk("served_count", {8'h00, served}, {8'h00, s0 + 8'h01});
    chk("taken_vector", last_vec, vec_tab[s]);
  endtask

  task automatic t_vectors;
    wr(ADDR_EN_FIRST, 8'hbf);
    wr(ADDR_EN_SECOND, 8'h3f);
    for (int s = 0; s < NUM_SRC; s++)
      serve_src(s);
  endtask

  task automatic t_global;
    wr(ADDR_EN_FIRST, 8'h0a);
    @(negedge clk);
    src_raw[1] = 1'b1;
    src_raw[3] = 1'b1;
    repeat (5) @(negedge clk);
    chk("gated_request", 16'(irq_req), 16'h0000);
    wr(ADDR_EN_FIRST, 8'h82);
    wait_for(0, 1'b1);
    chk("timer0_only", irq_vector, 16'h000b);
    wait_for(1, 1'b1);
    src_raw[1] = 1'b0;
    src_raw[3] = 1'b0;
    wait_for(1, 1'b0);
  endtask

  task automatic low_power(logic [7:0] a, logic [7:0] d, int w, int s, logic wakes);
    wr(a, d);
    wait_for(w, 1'b1);
    kick(s);
    if (wakes) begin
      wait_for(w, 1'b0);
    end else begin
      repeat (10) @(negedge clk);
      chk("held_low_power", 16'(sig(w)), 16'h0001);
    end
    wait_for(1, 1'b0);
  endtask

  task automatic t_wake;
    wr(ADDR_EN_FIRST, 8'h80);
    wr(ADDR_EN_SECOND, 8'h3f);
    wr(ADDR_WAKE, 8'h0c);
    low_power(ADDR_POWER, 8'h02, 2, 13, 1'b0);
    rd_chk("stop_reads_zero", ADDR_POWER, 8'h00);
    kick(12);
    wait_for(2, 1'b0);
    wr(ADDR_WAKE, 8'h00);
    low_power(ADDR_STBY, 8'h04, 4, 9, 1'b1);
    wr(ADDR_EN_SECOND, 8'h2f);
    wr(ADDR_WAKE, 8'h08);
    low_power(ADDR_POWER, 8'h01, 3, 13, 1'b1);
    rd_chk("idle_reads_zero", ADDR_POWER, 8'h00);
  endtask

  initial begin
    rst_b        = 1'b0;
    sfr_addr     = 8'h00;
    sfr_wdata    = 8'h00;
    sfr_wr       = 1'b0;
    sfr_rd       = 1'b0;
    src_raw      = 15'h0005;
    lf_clk_level = 1'b0;
    slow         = 1'b0;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    t_regs;
    t_vectors;
    t_global;
    t_wake;
    close_out;
  end
endmodule
